// ==== hw/dxcr_pkg.sv ====
// constants and carriers of the display extended control register bank
// assumes one 125 MHz clock and host access through the crt index/data port pair
package dxcr_pkg;

  // ==========================================================================
  // index decode
  localparam logic [1:0] EXT_BANK = 2'h2;
  localparam logic [7:0] IDX_INTERLACE_CONTROL = 8'h97;
  localparam logic [7:0] IDX_EQUALIZATION_START_LOW = 8'h9A;
  localparam logic [7:0] IDX_EQUALIZATION_END = 8'h9B;
  localparam logic [7:0] IDX_HALF_LINE_LOCATION = 8'h9C;
  localparam logic [7:0] IDX_MEMORY_TIMING_A = 8'h9D;
  localparam logic [7:0] IDX_MEMORY_TIMING_B = 8'h9E;
  localparam logic [7:0] IDX_VIDEO_FIFO_CONTROL = 8'hA0;
  localparam logic [7:0] IDX_PIXEL_PLL_MULTIPLIER = 8'hA1;
  localparam logic [7:0] IDX_PIXEL_PLL_DIVIDERS = 8'hA2;
  localparam logic [7:0] IDX_INTERFACE_CONTROL = 8'hA3;

  // ==========================================================================
  // field positions
  localparam int ICTL_EQ_HI_LSB = 6;
  localparam int ICTL_COMPOSITE_SYNC_ENABLE = 5;
  localparam int TA_CAS_PRECHARGE = 7;
  localparam int TA_CAS_WIDTH_LSB = 5;
  localparam int TA_HSYNC_LSB = 0;
  localparam int TB_IRQ_ENABLE = 6;
  localparam int TB_BURST = 5;
  localparam int TB_MUX_TO_COLUMN = 4;
  localparam int TB_ROW_TO_MUX = 3;
  localparam int TB_RAS_SETUP = 2;
  localparam int TB_RAS_PRECHARGE_LSB = 0;
  localparam int FC_RESET = 5;
  localparam int FC_ENABLE = 4;
  localparam int FC_DEPTH_LSB = 0;
  localparam int PM_M_LSB = 1;
  localparam int PM_DOT_SELECT = 0;
  localparam int PD_L_LSB = 4;
  localparam int PD_N_LSB = 0;
  localparam int IC_PARALLEL_LOAD = 5;
  localparam int IC_VSYNC_STROBE = 4;
  localparam int IC_WRAP_CLEAR_N = 3;
  localparam int IC_WRAP_FLAG = 2;

  // ==========================================================================
  // writable bits, reserved bits read as zero
  localparam logic [7:0] MASK_INTERLACE = 8'hF3;
  localparam logic [7:0] MASK_TIMING_B = 8'h7F;
  localparam logic [7:0] MASK_FIFO = 8'h3F;
  localparam logic [7:0] MASK_PLL_M = 8'h7F;
  localparam logic [7:0] MASK_PLL_D = 8'h3F;
  localparam logic [7:0] MASK_IFC = 8'h3B;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FIFO = 8'h18;
  localparam logic [7:0] RST_IFC = 8'h08;
  localparam logic [5:0] PCI_M_TERM = 6'h2A;
  localparam logic [3:0] PCI_N_TERM = 4'h6;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic data_sel;
    logic [7:0] wdata;
  } dxcr_host_req_t;

  typedef struct packed {
    logic enable;
    logic [9:0] eq_start;
    logic [7:0] eq_end;
    logic [7:0] half_line;
    logic [6:0] hsync_width;
  } dxcr_csync_t;

  typedef struct packed {
    logic [1:0] cas_precharge;
    logic [1:0] cas_width;
    logic [1:0] mux_to_column_delay;
    logic [1:0] row_to_mux_delay;
    logic [1:0] ras_setup;
    logic [2:0] ras_precharge;
    logic burst_enable;
  } dxcr_mem_timing_t;

  typedef struct packed {
    logic hold_reset;
    logic read_count_enable;
    logic [3:0] depth;
  } dxcr_fifo_ctl_t;

  typedef struct packed {
    logic use_lmn;
    logic [5:0] m_term;
    logic [3:0] n_term;
    logic [1:0] l_code;
    logic [3:0] l_divisor;
  } dxcr_pll_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] interlace_control;
    logic [7:0] equalization_start_low;
    logic [7:0] equalization_end;
    logic [7:0] half_line_location;
    logic [7:0] memory_timing_a;
    logic [7:0] memory_timing_b;
    logic [7:0] video_fifo_control;
    logic [7:0] pixel_pll_multiplier;
    logic [7:0] pixel_pll_dividers;
    logic [7:0] interface_control;
    logic fifo_wrapped_flag;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    dxcr_csync_t csync;
    dxcr_mem_timing_t timing;
    dxcr_fifo_ctl_t fifo;
    dxcr_pll_t pll;
  } dxcr_state_t;

endpackage : dxcr_pkg

// ==== hw/dxcr_regs.sv ====
// extended display control register bank behind the crt index/data pair
// assumes host strobes synchronous to clk, one strobe per cycle at most
`timescale 1ns/1ns

// What this block does
// RL1: ten-bit equalization start from two registers
// RL2: equalization end applied only with composite sync
// RL3: half-line location applied only with composite sync
// RL4: column-strobe precharge one or two clocks
// RL5: column-strobe width one, two or three
// RL6: hsync width 1 to 64 characters
// RL7: vertical sync interrupt gated by enable
// RL8: burst mode enable bit
// RL9: mux and row delays one or two
// RL10: row-strobe setup one or two clocks
// RL11: row-strobe precharge three, four, five, five
// RL12: fifo held in reset while set
// RL13: cleared bit stops fifo read counter
// RL14: one-hot fifo depth 1, 2, 4, 8
// RL15: multiplier term in bits 6:1
// RL16: pci reset plus gp interrupt loads 42/6
// RL17: bit 0 picks legacy or lmn clock
// RL18: pci reset forces dot select inverse gp
// RL19: output divider 1, 2, 4 or 8
// RL20: divisor term in bits 3:0
// RL21: software keeps pixel clock 8 to 135 MHz
// RL22: wrap flag readable, writes ignored
// RL23: writing zero clears wrap flag
// RL24: strobe bits drive pins directly
// RL25: software selects bank with index bits 10
// RL26: wrap flag sticky until cleared
module dxcr_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic general_purpose_interrupt_in_n,
  input wire dxcr_pkg::dxcr_host_req_t host_req,
  input wire logic vsync_pulse,
  input wire logic fifo_wrap_pulse,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic vsync_irq,
  output logic vertical_sync_strobe,
  output logic parallel_load_strobe,
  output dxcr_pkg::dxcr_csync_t csync,
  output dxcr_pkg::dxcr_mem_timing_t mem_timing,
  output dxcr_pkg::dxcr_fifo_ctl_t fifo_ctl,
  output dxcr_pkg::dxcr_pll_t pll
);
  import dxcr_pkg::*;

  // ==========================================================================
  // reset release
  logic [1:0] rst_pipe;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  // ==========================================================================
  // decoders
  function automatic dxcr_csync_t decode_csync(input logic [7:0] ictl,
                                              input logic [7:0] eqs,
                                              input logic [7:0] eqe,
                                              input logic [7:0] hln,
                                              input logic [7:0] tima);
    dxcr_csync_t c;
    logic [4:0] code;
    c = '0;
    code = tima[TA_HSYNC_LSB +: 5];
    c.enable = ictl[ICTL_COMPOSITE_SYNC_ENABLE];
    if (ictl[ICTL_COMPOSITE_SYNC_ENABLE]) begin
      c.eq_start = {ictl[ICTL_EQ_HI_LSB +: 2], eqs}; // RL1
      c.eq_end = eqe; // RL2
      c.half_line = hln; // RL3
      if (code == 5'h00) begin
        c.hsync_width = 7'h01; // RL6
      end else begin
        c.hsync_width = {1'b0, code, 1'b0} + 7'h02; // RL6
      end
    end
    return c;
  endfunction : decode_csync

  function automatic dxcr_mem_timing_t decode_timing(input logic [7:0] tima,
                                                     input logic [7:0] timb);
    dxcr_mem_timing_t t;
    logic [1:0] w;
    logic [1:0] rp;
    t = '0;
    w = tima[TA_CAS_WIDTH_LSB +: 2];
    rp = timb[TB_RAS_PRECHARGE_LSB +: 2];
    t.cas_precharge = tima[TA_CAS_PRECHARGE] ? 2'h2 : 2'h1; // RL4
    case (w)
      2'h0: t.cas_width = 2'h1; // RL5
      2'h1: t.cas_width = 2'h2; // RL5
      default: t.cas_width = 2'h3; // RL5
    endcase
    t.mux_to_column_delay = timb[TB_MUX_TO_COLUMN] ? 2'h2 : 2'h1; // RL9
    t.row_to_mux_delay = timb[TB_ROW_TO_MUX] ? 2'h2 : 2'h1; // RL9
    t.ras_setup = timb[TB_RAS_SETUP] ? 2'h2 : 2'h1; // RL10
    case (rp)
      2'h0: t.ras_precharge = 3'h3; // RL11
      2'h1: t.ras_precharge = 3'h4; // RL11
      default: t.ras_precharge = 3'h5; // RL11
    endcase
    t.burst_enable = timb[TB_BURST]; // RL8
    return t;
  endfunction : decode_timing

  function automatic dxcr_fifo_ctl_t decode_fifo(input logic [7:0] fc);
    dxcr_fifo_ctl_t f;
    f = '0;
    f.hold_reset = fc[FC_RESET]; // RL12
    f.read_count_enable = fc[FC_ENABLE]; // RL13
    case (fc[FC_DEPTH_LSB +: 4])
      4'h1: f.depth = 4'h1; // RL14
      4'h2: f.depth = 4'h2; // RL14
      4'h4: f.depth = 4'h4; // RL14
      default: f.depth = 4'h8; // RL14
    endcase
    return f;
  endfunction : decode_fifo

  function automatic dxcr_pll_t decode_pll(input logic [7:0] pm, input logic [7:0] pd);
    dxcr_pll_t p;
    p = '0;
    p.use_lmn = pm[PM_DOT_SELECT]; // RL17
    p.m_term = pm[PM_M_LSB +: 6]; // RL15
    p.n_term = pd[PD_N_LSB +: 4]; // RL20
    p.l_code = pd[PD_L_LSB +: 2];
    case (pd[PD_L_LSB +: 2])
      2'h0: p.l_divisor = 4'h1; // RL19
      2'h1: p.l_divisor = 4'h2; // RL19
      2'h2: p.l_divisor = 4'h4; // RL19
      default: p.l_divisor = 4'h8; // RL19
    endcase
    return p;
  endfunction : decode_pll

  // ==========================================================================
  // state
  dxcr_state_t st;
  dxcr_state_t next_st;
  logic ext_sel;
  logic [7:0] read_value;

  assign ext_sel = (st.index[7:6] == EXT_BANK); // RL25

  // readback of the indexed register
  always_comb begin
    read_value = 8'h00;
    if (ext_sel) begin
      case (st.index)
        IDX_INTERLACE_CONTROL: read_value = st.interlace_control;
        IDX_EQUALIZATION_START_LOW: read_value = st.equalization_start_low;
        IDX_EQUALIZATION_END: read_value = st.equalization_end;
        IDX_HALF_LINE_LOCATION: read_value = st.half_line_location;
        IDX_MEMORY_TIMING_A: read_value = st.memory_timing_a;
        IDX_MEMORY_TIMING_B: read_value = st.memory_timing_b;
        IDX_VIDEO_FIFO_CONTROL: read_value = st.video_fifo_control;
        IDX_PIXEL_PLL_MULTIPLIER: read_value = st.pixel_pll_multiplier;
        IDX_PIXEL_PLL_DIVIDERS: read_value = st.pixel_pll_dividers;
        IDX_INTERFACE_CONTROL: begin
          read_value = st.interface_control;
          read_value[IC_WRAP_FLAG] = st.fifo_wrapped_flag; // RL22
        end
        default: read_value = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.irq = 1'b0;
    if (!rst_sync_n) begin
      next_st.index = RST_ZERO;
      next_st.interlace_control = RST_ZERO;
      next_st.equalization_start_low = RST_ZERO;
      next_st.equalization_end = RST_ZERO;
      next_st.half_line_location = RST_ZERO;
      next_st.memory_timing_a = RST_ZERO;
      next_st.memory_timing_b = RST_ZERO;
      next_st.video_fifo_control = RST_FIFO;
      next_st.interface_control = RST_IFC;
      next_st.fifo_wrapped_flag = 1'b0;
      next_st.rdata = RST_ZERO;
      next_st.pixel_pll_multiplier = RST_ZERO;
      next_st.pixel_pll_dividers = RST_ZERO;
      if (!general_purpose_interrupt_in_n) begin
        next_st.pixel_pll_multiplier[PM_M_LSB +: 6] = PCI_M_TERM; // RL16
        next_st.pixel_pll_dividers[PD_N_LSB +: 4] = PCI_N_TERM; // RL16
      end
      next_st.pixel_pll_multiplier[PM_DOT_SELECT] = ~general_purpose_interrupt_in_n; // RL18
    end else begin
      // index and data port writes
      if (host_req.wr && !host_req.data_sel) begin
        next_st.index = host_req.wdata;
      end
      if (host_req.wr && host_req.data_sel && ext_sel) begin
        case (st.index)
          IDX_INTERLACE_CONTROL: begin
            next_st.interlace_control = host_req.wdata & MASK_INTERLACE;
          end
          IDX_EQUALIZATION_START_LOW: next_st.equalization_start_low = host_req.wdata;
          IDX_EQUALIZATION_END: next_st.equalization_end = host_req.wdata;
          IDX_HALF_LINE_LOCATION: next_st.half_line_location = host_req.wdata;
          IDX_MEMORY_TIMING_A: next_st.memory_timing_a = host_req.wdata;
          IDX_MEMORY_TIMING_B: next_st.memory_timing_b = host_req.wdata & MASK_TIMING_B;
          IDX_VIDEO_FIFO_CONTROL: next_st.video_fifo_control = host_req.wdata & MASK_FIFO;
          IDX_PIXEL_PLL_MULTIPLIER: begin
            next_st.pixel_pll_multiplier = host_req.wdata & MASK_PLL_M; // RL15
          end
          IDX_PIXEL_PLL_DIVIDERS: begin
            next_st.pixel_pll_dividers = host_req.wdata & MASK_PLL_D; // RL20
          end
          IDX_INTERFACE_CONTROL: next_st.interface_control = host_req.wdata & MASK_IFC; // RL22
          default: next_st.index = st.index;
        endcase
      end
      // reads answer one cycle later
      if (host_req.rd) begin
        next_st.rvalid = 1'b1;
        next_st.rdata = host_req.data_sel ? read_value : st.index;
      end
      // sticky wrap flag, a new wrap beats the clear
      if (fifo_wrap_pulse) begin
        next_st.fifo_wrapped_flag = 1'b1; // RL26
      end else if (!st.interface_control[IC_WRAP_CLEAR_N]) begin
        next_st.fifo_wrapped_flag = 1'b0; // RL23
      end
      next_st.irq = vsync_pulse && st.memory_timing_b[TB_IRQ_ENABLE]; // RL7
    end
    // registered decodes follow the register values
    next_st.csync = decode_csync(next_st.interlace_control, next_st.equalization_start_low,
                                 next_st.equalization_end, next_st.half_line_location,
                                 next_st.memory_timing_a);
    next_st.timing = decode_timing(next_st.memory_timing_a, next_st.memory_timing_b);
    next_st.fifo = decode_fifo(next_st.video_fifo_control);
    next_st.pll = decode_pll(next_st.pixel_pll_multiplier, next_st.pixel_pll_dividers);
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ==========================================================================
  // outputs
  assign host_rdata = st.rdata;
  assign host_rvalid = st.rvalid;
  assign vsync_irq = st.irq;
  assign vertical_sync_strobe = st.interface_control[IC_VSYNC_STROBE]; // RL24
  assign parallel_load_strobe = st.interface_control[IC_PARALLEL_LOAD]; // RL24
  assign csync = st.csync;
  assign mem_timing = st.timing;
  assign fifo_ctl = st.fifo;
  assign pll = st.pll;

endmodule : dxcr_regs

// ==== test/dxcr_regs_asserts.sv ====
// port-level checks of the extended control register bank
// assumes binding onto dxcr_regs, one clock, active-low reset
`timescale 1ns/1ns
module dxcr_regs_asserts
  import dxcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dxcr_pkg::dxcr_host_req_t host_req,
  input wire logic vsync_pulse,
  input wire logic host_rvalid,
  input wire logic vsync_irq,
  input wire logic vertical_sync_strobe,
  input wire logic parallel_load_strobe,
  input wire dxcr_pkg::dxcr_csync_t csync,
  input wire dxcr_pkg::dxcr_mem_timing_t mem_timing,
  input wire dxcr_pkg::dxcr_fifo_ctl_t fifo_ctl,
  input wire dxcr_pkg::dxcr_pll_t pll
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // assertions
  a_read_answered: assert property (host_req.rd |=> host_rvalid)
    else $error("read not answered");
  a_answer_needs_read: assert property (!host_req.rd |=> !host_rvalid)
    else $error("answer without read");
  a_irq_needs_vsync: assert property (!vsync_pulse |=> !vsync_irq)
    else $error("irq without vsync");
  a_csync_gated: assert property (!csync.enable |-> csync.eq_start == 10'h000 &&
    csync.eq_end == 8'h00 && csync.half_line == 8'h00 && csync.hsync_width == 7'h00)
    else $error("csync fields live while disabled");
  a_hsync_range: assert property (csync.enable |-> csync.hsync_width == 7'h01 ||
    (!csync.hsync_width[0] && csync.hsync_width inside {[7'h04:7'h40]}))
    else $error("hsync width out of range");
  a_cas_counts: assert property (mem_timing.cas_precharge inside {2'h1, 2'h2} &&
    mem_timing.cas_width != 2'h0)
    else $error("cas count out of range");
  a_ras_counts: assert property (mem_timing.ras_precharge inside {[3'h3:3'h5]} &&
    mem_timing.ras_setup inside {2'h1, 2'h2})
    else $error("ras count out of range");
  a_mux_delays: assert property (mem_timing.mux_to_column_delay inside {2'h1, 2'h2} &&
    mem_timing.row_to_mux_delay inside {2'h1, 2'h2})
    else $error("mux delay out of range");
  a_depth_onehot: assert property ($onehot(fifo_ctl.depth))
    else $error("fifo depth not one-hot");
  a_ldiv_map: assert property (pll.l_divisor == (4'h1 << pll.l_code))
    else $error("output divider mismatch");
  a_strobe_hold: assert property (!host_req.wr |=>
    $stable({vertical_sync_strobe, parallel_load_strobe}))
    else $error("strobe moved without write");
endmodule : dxcr_regs_asserts

bind dxcr_regs dxcr_regs_asserts u_chk (.clk(clk), .rst_n(rst_n), .host_req(host_req),
  .vsync_pulse(vsync_pulse), .host_rvalid(host_rvalid), .vsync_irq(vsync_irq),
  .vertical_sync_strobe(vertical_sync_strobe), .parallel_load_strobe(parallel_load_strobe),
  .csync(csync), .mem_timing(mem_timing), .fifo_ctl(fifo_ctl), .pll(pll));

// ==== test/testbench.sv ====
// self-checking bench of the extended control register bank
// assumes package, design and checker compiled before it
`timescale 1ns/1ns
module testbench;
  import dxcr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gp_n = 1'b0;
  dxcr_host_req_t req = '0;
  logic vs = 1'b0;
  logic wrap = 1'b0;
  logic [7:0] host_rdata;
  logic host_rvalid, vsync_irq, vss, pls;
  dxcr_csync_t csync;
  dxcr_mem_timing_t mt;
  dxcr_fifo_ctl_t fc;
  dxcr_pll_t pll;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] v, r;
  logic [4:0] h;
  logic [7:0] idx_tab [9] = '{8'h97, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'hA0, 8'hA1, 8'hA2};
  logic [7:0] msk_tab [9] = '{MASK_INTERLACE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, MASK_TIMING_B,
    MASK_FIFO, MASK_PLL_M, MASK_PLL_D};
  always #4 clk = ~clk;
  dxcr_regs uut (.clk(clk), .rst_n(rst_n), .general_purpose_interrupt_in_n(gp_n),
    .host_req(req), .vsync_pulse(vs), .fifo_wrap_pulse(wrap), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .vsync_irq(vsync_irq), .vertical_sync_strobe(vss),
    .parallel_load_strobe(pls), .csync(csync), .mem_timing(mt), .fifo_ctl(fc), .pll(pll));
  // ==========================================================================
  // helpers
  function automatic logic [1:0] cas_w(input logic [1:0] c);
    return (c == 2'h0) ? 2'h1 : ((c == 2'h1) ? 2'h2 : 2'h3);
  endfunction : cas_w
  function automatic logic [6:0] hs_w(input logic [4:0] c);
    return (c == 5'h00) ? 7'h01 : (({2'h0, c} + 7'h01) << 1);
  endfunction : hs_w
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic access(input logic w, input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{wr: w, rd: !w, data_sel: sel, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask : access
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    access(1'b1, 1'b0, idx);
    access(1'b1, 1'b1, d);
  endtask : put
  task automatic get(input logic [7:0] idx, input logic [7:0] exp);
    access(1'b1, 1'b0, idx);
    access(1'b0, 1'b1, 8'h00);
    chk(host_rvalid, 1'b1);
    chk(host_rdata, exp);
  endtask : get
  task automatic do_reset(input logic gp);
    #1 rst_n = 1'b0;
    gp_n = gp;
    repeat (5) @(posedge clk);
    #1 chk(pll.use_lmn, !gp);
    chk({pll.m_term, pll.n_term}, gp ? 10'h000 : {PCI_M_TERM, PCI_N_TERM});
    chk(fc, 6'h18);
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(30));
    do_reset(1'b0);
    get(8'hA1, 8'h55);
    get(8'hA3, RST_IFC);
    get(8'h99, 8'h00);
    access(1'b0, 1'b0, 8'h00);
    chk({host_rvalid, host_rdata}, 9'h199);
    put(8'h9D, 8'h00);
    put(8'h1D, 8'hFF);
    get(8'h9D, 8'h00);
    foreach (idx_tab[i]) begin
      v = 8'($urandom);
      put(idx_tab[i], v);
      get(idx_tab[i], v & msk_tab[i]);
    end
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      r = 8'($urandom);
      h = (k == 0) ? 5'h00 : ((k == 7) ? 5'h1F : v[4:0]);
      put(8'h97, {r[7:6], 6'h20});
      put(8'h9A, v);
      put(8'h9B, ~v);
      put(8'h9C, r);
      put(8'h9D, {k[2:0], h});
      chk({csync.enable, csync.eq_start}, {1'b1, r[7:6], v});
      chk({csync.eq_end, csync.half_line}, {~v, r});
      chk(mt.cas_precharge, {1'b0, k[2]} + 2'h1);
      chk(mt.cas_width, cas_w(k[1:0]));
      chk(csync.hsync_width, hs_w(h));
    end
    put(8'h97, 8'h00);
    chk(csync, '0);
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      v[1:0] = k[1:0];
      put(8'h9E, v);
      chk(mt.burst_enable, v[5]);
      chk({mt.mux_to_column_delay, mt.row_to_mux_delay, mt.ras_setup},
        {1'b0, v[4], 1'b0, v[3], 1'b0, v[2]} + 6'h15);
      chk(mt.ras_precharge, (k[1:0] == 2'h3) ? 3'h5 : 3'h3 + k[1:0]);
    end
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      put(8'hA0, {2'h0, v[5:4], 4'h1 << k});
      chk(fc, {v[5:4], 4'h1 << k});
      do begin
        v = 8'h19 + 8'($urandom % 39);
        r = 8'h04 + 8'($urandom % 12);
      end while (14318 * v < 8000 * r * (1 << k) ||
        14318 * v > 135000 * r * (1 << k));
      put(8'hA1, {1'b0, v[5:0], k[0]});
      put(8'hA2, {2'h0, k[1:0], r[3:0]});
      chk({pll.use_lmn, pll.m_term, pll.n_term, pll.l_code},
        {k[0], v[5:0], r[3:0], k[1:0]});
      chk(pll.l_divisor, 4'h1 << k);
    end
    for (int k = 0; k < 2; k++) begin
      put(8'h9E, k[0] ? 8'h00 : 8'h40);
      @(posedge clk);
      #1 vs = 1'b1;
      @(posedge clk);
      #1 vs = 1'b0;
      chk(vsync_irq, !k[0]);
      @(posedge clk);
      #1 chk(vsync_irq, 1'b0);
    end
    @(posedge clk);
    #1 wrap = 1'b1;
    @(posedge clk);
    #1 wrap = 1'b0;
    repeat (3) @(posedge clk);
    get(8'hA3, 8'h0C);
    put(8'hA3, 8'h38);
    chk({vss, pls}, 2'h3);
    get(8'hA3, 8'h3C);
    put(8'hA3, 8'h00);
    chk({vss, pls}, 2'h0);
    get(8'hA3, 8'h00);
    put(8'hA3, 8'h0C);
    get(8'hA3, 8'h08);
    do_reset(1'b1);
    get(8'hA1, 8'h00);
    final_report();
  end
endmodule : testbench
